/* hdl/lsd_pkg.sv */
package lsd_pkg;

    // core clock period and the clock count it implies per second
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam logic [23:0] CLK_HZ = 24'(64'd1_000_000_000 / CLK_PERIOD_NS);

    // frame refresh rate limits, in Hz
    localparam logic [7:0] RATE_MIN_HZ = 8'h0A;
    localparam logic [7:0] RATE_MAX_HZ = 8'h96;

    localparam int unsigned MAX_PINS = 62;
    localparam int unsigned MAX_COMMONS = 16;
    localparam int unsigned NUM_LEVELS = 6;
    localparam int unsigned CONTRAST_W = 6;
    localparam int unsigned FIFO_DEPTH = 4;

    // reset values of control state
    localparam logic [23:0] RST_ACC = 24'h000000;
    localparam logic [3:0] RST_COM = 4'h0;

    typedef enum logic [2:0] {
        LSD_BIAS_STATIC = 3'h0,
        LSD_BIAS_HALF = 3'h1,
        LSD_BIAS_THIRD = 3'h2,
        LSD_BIAS_QUARTER = 3'h3,
        LSD_BIAS_FIFTH = 3'h4
    } lsd_bias_t;

    typedef enum logic [1:0] {
        LSD_DRV_LOW = 2'h0,
        LSD_DRV_MID = 2'h1,
        LSD_DRV_HIGH = 2'h2
    } lsd_drive_t;

    typedef enum logic [1:0] {
        LSD_ST_IDLE = 2'h0,
        LSD_ST_FILL = 2'h1,
        LSD_ST_RUN = 2'h3
    } lsd_state_t;

    typedef struct packed {
        logic enable;
        lsd_bias_t bias;
        logic [CONTRAST_W-1:0] contrast;
        logic [7:0] rate_hz;
        logic invert;
        logic type_b;
        lsd_drive_t drive;
    } lsd_cfg_t;

    typedef struct packed {
        logic [NUM_LEVELS-1:0] level_en;
        logic [CONTRAST_W-1:0] contrast;
        lsd_drive_t drive;
    } lsd_biasbus_t;

    typedef struct packed {
        logic active;
        logic [3:0] com;
        logic polarity;
        logic slot_tick;
    } lsd_ctrl_t;

endpackage

/* hdl/lsd_lcd_drive.sv */
`timescale 1ns/1ps

module lsd_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } lsd_fifo_state_t;

    lsd_fifo_state_t s_q;
    lsd_fifo_state_t s_d;
    logic push;
    logic pop;

    assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data = s_q.mem[s_q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop)
        begin
            s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
        end
        if (push && !pop)
        begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        // a flush drops stale words when the display is switched off
        if (flush)
        begin
            s_d.wr = '0;
            s_d.rd = '0;
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule

module lsd_lcd_drive #(
    parameter int unsigned NPINS = lsd_pkg::MAX_PINS,
    parameter int unsigned DEPTH = lsd_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire lsd_pkg::lsd_cfg_t cfg,
    input wire logic [NPINS-1:0] pin_is_common,
    output logic dma_req,
    input wire logic dma_valid,
    output logic dma_ready,
    input wire logic [NPINS-1:0] dma_data,
    input wire logic underrun_clr,
    output logic underrun,
    output lsd_pkg::lsd_ctrl_t lcd_ctrl,
    output lsd_pkg::lsd_biasbus_t bias_bus,
    output logic [NPINS-1:0][2:0] pin_level
);
    typedef struct packed {
        lsd_pkg::lsd_state_t st;
        logic [23:0] acc;
        logic [3:0] com;
        logic half;
        logic pol;
        logic pre_vld;
        logic [NPINS-1:0] pre;
        logic [NPINS-1:0] act;
        logic underrun;
        logic req;
        logic tick;
        logic [NPINS-1:0][2:0] lvl;
        lsd_pkg::lsd_biasbus_t bias;
    } lsd_state_t;

    lsd_state_t s_q;
    lsd_state_t s_d;
    logic f_valid;
    logic f_ready;
    logic [NPINS-1:0] f_data;
    logic [4:0] ncom;
    logic [7:0] rate;
    logic [12:0] prod;
    logic [12:0] step;
    logic [24:0] acc_sum;
    logic [2:0] top_lvl;
    logic [NPINS-1:0][4:0] rank;

    // level for one pin: 0 is ground, top is the full bias voltage
    function automatic logic [2:0] lsd_level(
        input logic is_com,
        input logic sel,
        input logic on,
        input logic p,
        input logic [2:0] a
    );
        logic [2:0] lv;
        lv = 3'h0;
        if (is_com)
        begin
            if (sel)
            begin
                lv = p ? 3'h0 : a;
            end
            else if (a < 3'h2)
            begin
                lv = p ? 3'h0 : a;
            end
            else
            begin
                lv = p ? a - 3'h1 : 3'h1;
            end
        end
        else if (on)
        begin
            lv = p ? a : 3'h0;
        end
        else if (a < 3'h2)
        begin
            // static drive: off segments follow the common
            lv = p ? 3'h0 : a;
        end
        else
        begin
            lv = p ? a - 3'h2 : 3'h2;
        end
        return lv;
    endfunction

    lsd_fifo #(
        .WIDTH(NPINS),
        .DEPTH(DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .resetn(resetn),
        .flush(s_q.st == lsd_pkg::LSD_ST_IDLE),
        .in_valid(dma_valid),
        .in_ready(dma_ready),
        .in_data(dma_data),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // rank of each common pin among the commons below it
    always_comb
    begin
        logic [4:0] n;
        n = 5'h0;
        for (int i = 0; i < NPINS; i++)
        begin
            rank[i] = n;
            if (pin_is_common[i] && n != 5'h1F)
            begin
                n = n + 5'h1;
            end
        end
        if (n == 5'h0)
        begin
            ncom = 5'h1;
        end
        else if (n > 5'(lsd_pkg::MAX_COMMONS))
        begin
            ncom = 5'(lsd_pkg::MAX_COMMONS);
        end
        else
        begin
            ncom = n;
        end
    end

    always_comb
    begin
        if (cfg.rate_hz < lsd_pkg::RATE_MIN_HZ)
        begin
            rate = lsd_pkg::RATE_MIN_HZ;
        end
        else if (cfg.rate_hz > lsd_pkg::RATE_MAX_HZ)
        begin
            rate = lsd_pkg::RATE_MAX_HZ;
        end
        else
        begin
            rate = cfg.rate_hz;
        end
        case (cfg.bias)
            lsd_pkg::LSD_BIAS_STATIC: top_lvl = 3'h1;
            lsd_pkg::LSD_BIAS_HALF: top_lvl = 3'h2;
            lsd_pkg::LSD_BIAS_THIRD: top_lvl = 3'h3;
            lsd_pkg::LSD_BIAS_QUARTER: top_lvl = 3'h4;
            lsd_pkg::LSD_BIAS_FIFTH: top_lvl = 3'h5;
            default: top_lvl = 3'h3;
        endcase
    end

    // slots per second: Type A spends two slots per common
    assign prod = 13'(rate) * 13'(ncom);
    assign step = cfg.type_b ? prod : 13'(prod << 1);
    assign acc_sum = {1'b0, s_q.acc} + 25'(step);
    assign f_ready = (s_q.st != lsd_pkg::LSD_ST_IDLE) && !s_q.pre_vld;

    always_comb
    begin
        logic adv;
        logic p;
        s_d = s_q;
        adv = 1'b0;
        p = 1'b0;
        s_d.req = 1'b0;
        s_d.tick = 1'b0;
        case (s_q.st)
            lsd_pkg::LSD_ST_IDLE:
            begin
                s_d.acc = lsd_pkg::RST_ACC;
                s_d.com = lsd_pkg::RST_COM;
                s_d.half = 1'b0;
                s_d.pol = 1'b0;
                s_d.pre_vld = 1'b0;
                if (cfg.enable)
                begin
                    s_d.st = lsd_pkg::LSD_ST_FILL;
                    s_d.req = 1'b1;
                end
            end
            lsd_pkg::LSD_ST_FILL:
            begin
                // first common is loaded before its slot begins
                if (s_q.pre_vld)
                begin
                    s_d.act = s_q.pre;
                    s_d.pre_vld = 1'b0;
                    s_d.st = lsd_pkg::LSD_ST_RUN;
                    s_d.req = (ncom == 5'h1);
                end
            end
            lsd_pkg::LSD_ST_RUN:
            begin
                if (acc_sum >= {1'b0, lsd_pkg::CLK_HZ})
                begin
                    s_d.acc = 24'(acc_sum - {1'b0, lsd_pkg::CLK_HZ});
                    s_d.tick = 1'b1;
                    if (!cfg.type_b && !s_q.half)
                    begin
                        s_d.half = 1'b1;
                    end
                    else
                    begin
                        s_d.half = 1'b0;
                        adv = 1'b1;
                    end
                end
                else
                begin
                    s_d.acc = acc_sum[23:0];
                end
                if (adv)
                begin
                    if (5'(s_q.com) >= ncom - 5'h1)
                    begin
                        s_d.com = 4'h0;
                        // Type B flips polarity once per frame
                        s_d.pol = ~s_q.pol;
                    end
                    else
                    begin
                        s_d.com = s_q.com + 4'h1;
                    end
                    // next frame is asked for as its last common starts
                    s_d.req = (5'(s_d.com) == ncom - 5'h1);
                    if (s_q.pre_vld)
                    begin
                        s_d.act = s_q.pre;
                        s_d.pre_vld = 1'b0;
                    end
                    else
                    begin
                        s_d.underrun = 1'b1;
                    end
                end
                if (!cfg.enable)
                begin
                    s_d.st = lsd_pkg::LSD_ST_IDLE;
                end
            end
            default:
            begin
                s_d.st = lsd_pkg::LSD_ST_IDLE;
            end
        endcase
        if (s_q.st == lsd_pkg::LSD_ST_FILL && !cfg.enable)
        begin
            s_d.st = lsd_pkg::LSD_ST_IDLE;
        end
        // prefetch uses the registered flag so a word never overwrites
        if (f_ready && f_valid)
        begin
            s_d.pre = f_data;
            s_d.pre_vld = 1'b1;
        end
        // a new underrun wins over a clear in the same cycle
        if (underrun_clr && !(adv && !s_q.pre_vld))
        begin
            s_d.underrun = 1'b0;
        end
        p = cfg.type_b ? s_d.pol : s_d.half;
        for (int i = 0; i < NPINS; i++)
        begin
            if (s_d.st != lsd_pkg::LSD_ST_RUN)
            begin
                s_d.lvl[i] = 3'h0;
            end
            else if (pin_is_common[i] && rank[i] >= ncom)
            begin
                // commons past the sixteenth are held at ground
                s_d.lvl[i] = 3'h0;
            end
            else
            begin
                s_d.lvl[i] = lsd_level(pin_is_common[i],
                    rank[i] == 5'(s_d.com),
                    s_d.act[i] ^ cfg.invert, p, top_lvl);
            end
        end
        s_d.bias.level_en = '0;
        s_d.bias.contrast = '0;
        s_d.bias.drive = lsd_pkg::LSD_DRV_LOW;
        if (s_d.st == lsd_pkg::LSD_ST_RUN)
        begin
            for (int k = 0; k < lsd_pkg::NUM_LEVELS; k++)
            begin
                s_d.bias.level_en[k] = (3'(k) <= top_lvl);
            end
            s_d.bias.contrast = cfg.contrast;
            case (cfg.drive)
                lsd_pkg::LSD_DRV_LOW: s_d.bias.drive = lsd_pkg::LSD_DRV_LOW;
                lsd_pkg::LSD_DRV_MID: s_d.bias.drive = lsd_pkg::LSD_DRV_MID;
                lsd_pkg::LSD_DRV_HIGH: s_d.bias.drive = lsd_pkg::LSD_DRV_HIGH;
                default: s_d.bias.drive = lsd_pkg::LSD_DRV_HIGH;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign dma_req = s_q.req;
    assign underrun = s_q.underrun;
    assign lcd_ctrl.active = (s_q.st == lsd_pkg::LSD_ST_RUN);
    assign lcd_ctrl.com = s_q.com;
    assign lcd_ctrl.polarity = cfg.type_b ? s_q.pol : s_q.half;
    assign lcd_ctrl.slot_tick = s_q.tick;
    assign bias_bus = s_q.bias;
    assign pin_level = s_q.lvl;
endmodule

/* test/lsd_glass.sv */
`timescale 1ns/1ps
module lsd_glass #(
    parameter int unsigned NPINS = 20,
    parameter int unsigned NCOM = 16
) (
    input wire logic [NPINS-1:0][2:0] pin_level,
    input wire logic [3:0] com,
    input wire logic [2:0] top,
    output logic [NPINS-NCOM-1:0] lit
);
    // passive cell: only the full bias swing across it turns a pixel dark
    always_comb
    begin
        for (int s = 0; s < NPINS - NCOM; s++)
        begin
            lit[s] = 3'((pin_level[com] > pin_level[NCOM + s]) ?
                pin_level[com] - pin_level[NCOM + s] :
                pin_level[NCOM + s] - pin_level[com]) == top;
        end
    end
endmodule

/* test/lsd_lcd_monitor.sv */
`timescale 1ns/1ps
module lsd_lcd_monitor #(
    parameter int unsigned NPINS = 62
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire lsd_pkg::lsd_cfg_t cfg,
    input wire logic [NPINS-1:0] pin_is_common,
    input wire logic dma_req,
    input wire logic dma_valid,
    input wire logic dma_ready,
    input wire logic [NPINS-1:0] dma_data,
    input wire logic underrun_clr,
    input wire logic underrun,
    input wire lsd_pkg::lsd_ctrl_t lcd_ctrl,
    input wire lsd_pkg::lsd_biasbus_t bias_bus,
    input wire logic [NPINS-1:0][2:0] pin_level
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_start;
        !lcd_ctrl.active && $rose(cfg.enable);
    endsequence
    sequence s_idle3;
        !lcd_ctrl.active [*3];
    endsequence
    property p_run(c, x);
        lcd_ctrl.active && $past(lcd_ctrl.active) && c |-> x;
    endproperty
    start_asks_a: assert property (s_start |=> dma_req)
        else $error("no frame request after enable");
    req_pulse_a: assert property (dma_req |=> !dma_req)
        else $error("frame request longer than one cycle");
    tick_gap_a: assert property (lcd_ctrl.slot_tick |=>
        !lcd_ctrl.slot_tick [*8]) else $error("slot ticks too close");
    scan_on_tick_a: assert property (($changed(lcd_ctrl.com) ||
        $changed(lcd_ctrl.polarity)) && $past(lcd_ctrl.active) &&
        lcd_ctrl.active |-> lcd_ctrl.slot_tick || $past(lcd_ctrl.slot_tick))
        else $error("scan moved without a slot tick");
    idle_quiet_a: assert property (s_idle3 |->
        $past(bias_bus) == '0 && $past(pin_level) == '0)
        else $error("levels driven while idle");
    stop_idle_a: assert property (!cfg.enable |=> !lcd_ctrl.active)
        else $error("still running after disable");
    idle_ready_a: assert property (!cfg.enable [*3] |-> dma_ready)
        else $error("stream not ready while idle");
    contrast_pass_a: assert property (p_run(1'b1,
        bias_bus.contrast == $past(cfg.contrast)))
        else $error("contrast not carried to bias bus");
    drive_mode_a: assert property (p_run($past(cfg.drive) != 2'h3,
        bias_bus.drive == $past(cfg.drive))) else $error("drive mode wrong");
    quarter_en_a: assert property (p_run(
        $past(cfg.bias) == lsd_pkg::LSD_BIAS_QUARTER,
        bias_bus.level_en == 6'h1F)) else $error("quarter bias levels wrong");
    underrun_hold_a: assert property (underrun && !underrun_clr
        |=> underrun) else $error("underrun flag lost");
endmodule
bind lsd_lcd_drive lsd_lcd_monitor #(.NPINS(NPINS)) u_mon (
    .core_clk(core_clk), .resetn(resetn), .cfg(cfg),
    .pin_is_common(pin_is_common), .dma_req(dma_req),
    .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_data(dma_data),
    .underrun_clr(underrun_clr), .underrun(underrun),
    .lcd_ctrl(lcd_ctrl), .bias_bus(bias_bus), .pin_level(pin_level)
);

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    lsd_pkg::lsd_cfg_t cfg = '0;
    logic [19:0] pin_is_common = 20'h0FFFF;
    logic dma_req;
    logic dma_valid = 1'b0;
    logic dma_ready;
    logic [19:0] dma_data = 20'h00000;
    logic underrun_clr = 1'b0;
    logic underrun;
    lsd_pkg::lsd_ctrl_t lcd_ctrl;
    lsd_pkg::lsd_biasbus_t bias_bus;
    logic [19:0][2:0] pin_level;
    logic [2:0] top = 3'h4;
    logic [3:0] lit;
    logic p0;
    bit starve = 1'b0;
    int errors = 0;
    int total_checks = 0;
    int sent = 0;
    int avail = 0;
    int n_req = 0;
    int cyc = 0;
    int n;

    always #50 core_clk = ~core_clk;

    lsd_lcd_drive #(.NPINS(20), .DEPTH(4)) u_dut (
        .core_clk(core_clk), .resetn(resetn), .cfg(cfg),
        .pin_is_common(pin_is_common), .dma_req(dma_req),
        .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_data(dma_data),
        .underrun_clr(underrun_clr), .underrun(underrun),
        .lcd_ctrl(lcd_ctrl), .bias_bus(bias_bus), .pin_level(pin_level)
    );
    lsd_glass #(.NPINS(20), .NCOM(16)) u_glass (
        .pin_level(pin_level), .com(lcd_ctrl.com), .top(top), .lit(lit)
    );

    function automatic logic [3:0] segs(input int c);
        return 4'(c) ^ 4'h6;
    endfunction

    // memory side: 16 words after each request, one when starve is set, common 0 first
    always @(posedge core_clk)
    begin
        if (dma_valid && dma_ready)
            sent++;
        if (dma_req)
        begin
            avail += starve ? 1 : 16;
            n_req++;
        end
        if (!cfg.enable)
        begin
            sent = 0;
            avail = 0;
        end
        #1;
        dma_valid = sent < avail;
        // all data lines invert while no word is valid so stale words cannot pass
        dma_data = {segs(sent % 16), 16'hFFFF} ^ {20{!dma_valid}};
    end

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            errors++;
            $display("[ERR] %0t run too long", $time);
            end_sim;
        end
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic wait_active;
        for (int i = 0; i < 60 && lcd_ctrl.active !== 1'b1; i++)
            step(1);
    endtask

    task automatic wait_tick(output int k);
        k = 0;
        do
        begin
            step(1);
            k++;
        end
        while (lcd_ctrl.slot_tick !== 1'b1 && k < 9000);
    endtask

    task automatic t_start;
        cfg = '{1'b1, lsd_pkg::LSD_BIAS_QUARTER, 6'h2A, 8'hFF, 1'b0,
            1'b0, lsd_pkg::LSD_DRV_MID};
        wait_active;
        chk(32'(lcd_ctrl.com), 32'h0);
        chk(32'(bias_bus), 32'({6'h1F, 6'h2A, 2'h1}));
        chk(32'(pin_level[0]), 32'h4);
        chk(32'(pin_level[1]), 32'h1);
        chk(32'(pin_level[19:16]), 32'({3'h2, 3'h0, 3'h0, 3'h2}));
        chk(32'(lit), 32'(segs(0)));
        $display("start done");
    endtask

    task automatic t_levels;
        for (int b = 0; b < 5; b++)
        begin
            cfg.bias = lsd_pkg::lsd_bias_t'(b);
            top = 3'(b + 1);
            step(2);
            chk(32'(bias_bus.level_en), (32'h4 << b) - 1);
            chk(32'(pin_level[0]), 32'(top));
            chk(32'(lit), 32'(segs(0)));
        end
        for (int d = 0; d < 3; d++)
        begin
            cfg.drive = lsd_pkg::lsd_drive_t'(d);
            step(2);
            chk(32'(bias_bus.drive), 32'(d));
        end
        cfg.contrast = 6'h3F;
        cfg.invert = 1'b1;
        cfg.bias = lsd_pkg::LSD_BIAS_QUARTER;
        top = 3'h4;
        step(2);
        chk(32'(bias_bus.contrast), 32'h3F);
        chk(32'(lit), 32'(segs(0) ^ 4'hF));
        cfg.invert = 1'b0;
        $display("levels done");
    endtask

    task automatic t_scan;
        wait_tick(n);
        step(1);
        chk(32'(lcd_ctrl.polarity), 32'h1);
        chk(32'(lcd_ctrl.com), 32'h0);
        chk(32'(pin_level[3:0]), 32'({3'h3, 3'h3, 3'h3, 3'h0}));
        wait_tick(n);
        // rate above the top clamps: 16 commons, two slots each
        chk(32'(n >= 2082 && n <= 2083), 32'h1);
        step(1);
        chk(32'(lcd_ctrl.com), 32'h1);
        chk(32'(lit), 32'(segs(1)));
        cfg.type_b = 1'b1;
        wait_tick(n);
        step(1);
        chk(32'(lcd_ctrl.com), 32'h2);
        n = n_req;
        for (int i = 0; i < 60000 && lcd_ctrl.com !== 4'hF; i++)
            step(1);
        step(2);
        chk(32'(n_req - n), 32'h1);
        p0 = lcd_ctrl.polarity;
        wait_tick(n);
        step(1);
        chk(32'(lcd_ctrl.com), 32'h0);
        chk(32'(lcd_ctrl.polarity), 32'(p0 ^ 1'b1));
        chk(32'(lit), 32'(segs(0)));
        $display("scan done");
    endtask

    task automatic t_underrun;
        cfg.enable = 1'b0;
        step(3);
        chk(32'(lcd_ctrl.active), 32'h0);
        chk(32'(dma_ready), 32'h1);
        starve = 1'b1;
        cfg.enable = 1'b1;
        wait_active;
        wait_tick(n);
        step(1);
        chk(32'(underrun), 32'h1);
        chk(32'(lit), 32'(segs(0)));
        // a seventeenth common has no slot and must sit at ground
        pin_is_common = 20'h1FFFF;
        step(2);
        chk(32'(pin_level[16]), 32'h0);
        pin_is_common = 20'h0FFFF;
        step(2);
        chk(32'(pin_level[16]), 32'h2);
        underrun_clr = 1'b1;
        step(1);
        underrun_clr = 1'b0;
        step(1);
        chk(32'(underrun), 32'h0);
        $display("underrun done");
    endtask

    initial
    begin
        step(2);
        resetn = 1'b1;
        chk(32'(dma_ready), 32'h1);
        chk(32'(lcd_ctrl), 32'h0);
        chk(32'(|pin_level), 32'h0);
        $display("reset done");
        step(1);
        t_start;
        t_levels;
        t_scan;
        t_underrun;
        end_sim;
    end
endmodule
